// ---- logic/byte_fifo.v ----
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
)(
	// Clock and reset
	input  wire             i_ref_clk,
	input  wire             i_rstn,
	// Fill side
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	// Drain side
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_r;
	reg [AW-1:0]    rd_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;
	assign o_in_ready  = (cnt_r != DEPTH);
	assign o_out_valid = (cnt_r != 0);
	assign o_out_data  = mem[rd_r];
	assign push = i_in_valid & o_in_ready;
	assign pop  = o_out_valid & i_out_ready;
	always @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			wr_r  <= {AW{1'b0}};
			rd_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem[wr_r] <= i_in_data;
				wr_r      <= wr_r + 1'b1;
			end
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // byte_fifo

// ---- logic/e1_slot_control.v ----
// Per-slot channel control and one-second error latches of an E1 framer
`timescale 1ns/1ps
`include "slot_ctrl_defines.vh"
module e1_slot_control #(
	parameter ONE_SEC_CYCLES = `ONE_SEC_CYCLES
)(
	// Clock and reset
	input  wire       i_ref_clk,
	input  wire       i_rstn,
	// Microprocessor port (page register selects the page)
	input  wire [4:0] i_page,
	input  wire [4:0] i_addr,
	input  wire       i_cs,
	input  wire       i_wr,
	input  wire [7:0] i_wdata,
	output reg  [7:0] o_rdata,
	// Slot timing: one byte per slot, strobe marks a slot period
	input  wire       i_slot_strobe,
	input  wire [4:0] i_slot_num,
	// Backplane input stream byte and message buffer byte for this slot
	input  wire [7:0] i_backplane_data_input,
	input  wire [7:0] i_msg_buffer_data,
	// Received line byte for this slot
	input  wire [7:0] i_rx_line_data,
	// Transmit line side, buffered
	output wire       o_tx_valid,
	output wire [7:0] o_tx_data,
	output wire [4:0] o_tx_slot,
	input  wire       i_tx_ready,
	output wire       o_tx_stall,
	// Backplane output stream
	output reg  [7:0] o_backplane_data_output,
	output reg        o_backplane_valid,
	// PRBS checker state
	output reg        o_prbs_locked,
	output reg        o_prbs_error,
	// Error events from the framer, one-cycle pulses
	input  wire       i_ebit_err,
	input  wire       i_fas_err,
	input  wire       i_bpv_err,
	input  wire       i_crc_err,
	output reg        o_one_sec_tick
);
	reg  [7:0]  slot_ctrl_r [0:31];
	reg         test_pattern_select_r;
	reg  [31:0] sec_cnt_r;
	reg  [9:0]  ebit_run_r;
	reg  [7:0]  fas_run_r;
	reg  [15:0] bpv_run_r;
	reg  [9:0]  crc_run_r;
	reg  [9:0]  ebit_lat_r;
	reg  [7:0]  fas_lat_r;
	reg  [15:0] bpv_lat_r;
	reg  [9:0]  crc_lat_r;
	reg  [14:0] prbs_gen_r;
	reg  [14:0] prbs_chk_r;
	reg  [4:0]  lock_cnt_r;
	reg  [2:0]  mw_idx_r;
	reg  [7:0]  tx_byte;
	reg  [7:0]  rx_byte;
	reg  [7:0]  ctl;
	reg  [7:0]  tx_src;
	reg  [7:0]  rx_in;
	reg  [7:0]  chk_exp;
	reg  [14:0] chk_nxt;
	reg  [7:0]  chk_diff;
	reg  [14:0] prbs_gen_nxt;
	reg  [7:0]  prbs_byte;
	wire        tx_ready;
	wire        wr_en;
	wire        slot_wr;
	wire [4:0]  wr_slot;
	reg  [22:0] gen_full;
	reg  [22:0] chk_full;
	integer     i;

	// Eight bits of the PRBS shift out MSB first; x^15+x^14+1
	function [22:0] prbs8;
		input [14:0] s;
		reg   [14:0] t;
		reg   [7:0]  o;
		integer      k;
		begin
			t = s;
			o = 8'h00;
			for (k = 7; k >= 0; k = k - 1)
			begin
				o[k] = t[14] ^ t[13];
				t    = {t[13:0], o[k]};
			end
			prbs8 = {t, o};
		end
	endfunction

	// A-law digital milliwatt, one 8-byte cycle
	function [7:0] milliwatt;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: milliwatt = 8'h34;
				3'h1: milliwatt = 8'h21;
				3'h2: milliwatt = 8'h21;
				3'h3: milliwatt = 8'h34;
				3'h4: milliwatt = 8'hb4;
				3'h5: milliwatt = 8'ha1;
				3'h6: milliwatt = 8'ha1;
				default: milliwatt = 8'hb4;
			endcase
		end
	endfunction

	assign wr_en   = i_cs & i_wr;
	assign slot_wr = wr_en & i_addr[4] & ((i_page == `PG_SLOT_LOW) | (i_page == `PG_SLOT_HIGH));
	assign wr_slot = {i_page == `PG_SLOT_HIGH, i_addr[3:0]};
	assign o_tx_stall = ~tx_ready;

	// Register writes and reads
	always @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			for (i = 0; i < 32; i = i + 1)
				slot_ctrl_r[i] <= `SLOT_CTRL_RESET;
			test_pattern_select_r <= 1'b0;
		end
		else
		begin
			if (slot_wr)
				slot_ctrl_r[wr_slot] <= {i_wdata[7:2], 2'b00};
			if (wr_en && i_page == `PG_CONFIG && i_addr == `OFS_CONFIG)
				test_pattern_select_r <= i_wdata[`BIT_PAT_SEL];
		end
	end

	always @*
	begin
		o_rdata = 8'h00;
		if (i_cs && !i_wr)
		begin
			if ((i_page == `PG_SLOT_LOW || i_page == `PG_SLOT_HIGH) && i_addr[4])
				o_rdata = slot_ctrl_r[wr_slot];
			else if (i_page == `PG_CONFIG && i_addr == `OFS_CONFIG)
				o_rdata = {7'h00, test_pattern_select_r};
			else if (i_page == `PG_STATUS)
			begin
				case (i_addr)
					`OFS_EBIT_UP: o_rdata = {6'h00, ebit_lat_r[9:8]};
					`OFS_EBIT_LO: o_rdata = ebit_lat_r[7:0];
					`OFS_FAS:     o_rdata = fas_lat_r;
					`OFS_BPV_UP:  o_rdata = bpv_lat_r[15:8];
					`OFS_BPV_LO:  o_rdata = bpv_lat_r[7:0];
					`OFS_CRC_UP:  o_rdata = {6'h00, crc_lat_r[9:8]};
					`OFS_CRC_LO:  o_rdata = crc_lat_r[7:0];
					default:      o_rdata = 8'h00;
				endcase
			end
		end
	end

	// One-second timer and error counters; running counts restart at each tick
	always @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			sec_cnt_r      <= 32'h0;
			o_one_sec_tick <= 1'b0;
			ebit_run_r     <= 10'h000;
			fas_run_r      <= 8'h00;
			bpv_run_r      <= 16'h0000;
			crc_run_r      <= 10'h000;
			ebit_lat_r     <= 10'h000;
			fas_lat_r      <= 8'h00;
			bpv_lat_r      <= 16'h0000;
			crc_lat_r      <= 10'h000;
		end
		else
		begin
			o_one_sec_tick <= (sec_cnt_r == ONE_SEC_CYCLES - 1);
			if (sec_cnt_r == ONE_SEC_CYCLES - 1)
			begin
				sec_cnt_r  <= 32'h0;
				// Event in the tick cycle is counted into the latched value
				ebit_lat_r <= (i_ebit_err && ebit_run_r != 10'h3ff) ? ebit_run_r + 10'h001 : ebit_run_r;
				fas_lat_r  <= (i_fas_err && fas_run_r != 8'hff) ? fas_run_r + 8'h01 : fas_run_r;
				bpv_lat_r  <= (i_bpv_err && bpv_run_r != 16'hffff) ? bpv_run_r + 16'h0001 : bpv_run_r;
				crc_lat_r  <= (i_crc_err && crc_run_r != 10'h3ff) ? crc_run_r + 10'h001 : crc_run_r;
				ebit_run_r <= 10'h000;
				fas_run_r  <= 8'h00;
				bpv_run_r  <= 16'h0000;
				crc_run_r  <= 10'h000;
			end
			else
			begin
				sec_cnt_r <= sec_cnt_r + 32'h1;
				// Counters saturate rather than wrap so an overload reads as full scale
				if (i_ebit_err && ebit_run_r != 10'h3ff)
					ebit_run_r <= ebit_run_r + 10'h001;
				if (i_fas_err && fas_run_r != 8'hff)
					fas_run_r <= fas_run_r + 8'h01;
				if (i_bpv_err && bpv_run_r != 16'hffff)
					bpv_run_r <= bpv_run_r + 16'h0001;
				if (i_crc_err && crc_run_r != 10'h3ff)
					crc_run_r <= crc_run_r + 10'h001;
			end
		end
	end

	// Per-slot data path
	always @*
	begin
		ctl       = slot_ctrl_r[i_slot_num];
		gen_full     = prbs8(prbs_gen_r);
		prbs_gen_nxt = gen_full[22:8];
		prbs_byte    = gen_full[7:0];
		tx_src    = ctl[`BIT_TX_MSG] ? i_msg_buffer_data : i_backplane_data_input;
		rx_in     = i_rx_line_data;
		if (ctl[`BIT_ADI])
		begin
			// Message buffer bytes go out as stored; backplane transmit data and received line data have alternate bits inverted (ADI_MASK)
			tx_src = ctl[`BIT_TX_MSG] ? tx_src : tx_src ^ `ADI_MASK;
			rx_in  = rx_in ^ `ADI_MASK;
		end
		tx_byte = tx_src;
		if (ctl[`BIT_REMOTE_LB])
			tx_byte = rx_in;
		if (ctl[`BIT_TX_TEST])
			tx_byte = test_pattern_select_r ? milliwatt(mw_idx_r) : prbs_byte;
		rx_byte = rx_in;
		if (ctl[`BIT_LOCAL_LB])
			rx_byte = tx_byte;
		if (ctl[`BIT_RX_TEST] && test_pattern_select_r)
			rx_byte = milliwatt(mw_idx_r);
		chk_full = prbs8(prbs_chk_r);
		chk_nxt  = chk_full[22:8];
		chk_exp  = chk_full[7:0];
		chk_diff = chk_exp ^ rx_in;
	end

	// Stream outputs, test generators and PRBS checker
	always @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			o_backplane_data_output <= 8'h00;
			o_backplane_valid       <= 1'b0;
			prbs_gen_r    <= `PRBS_SEED;
			prbs_chk_r    <= `PRBS_SEED;
			lock_cnt_r    <= 5'h00;
			o_prbs_locked <= 1'b0;
			o_prbs_error  <= 1'b0;
			mw_idx_r      <= 3'h0;
		end
		else
		begin
			o_backplane_valid <= i_slot_strobe;
			o_prbs_error      <= 1'b0;
			if (i_slot_strobe)
			begin
				o_backplane_data_output <= rx_byte;
				if (ctl[`BIT_TX_TEST] && tx_ready)
				begin
					// One generator shared by all test slots keeps one continuous sequence
					if (test_pattern_select_r)
						mw_idx_r <= mw_idx_r + 3'h1;
					else
						prbs_gen_r <= prbs_gen_nxt;
				end
				if (ctl[`BIT_RX_TEST] && test_pattern_select_r && !ctl[`BIT_TX_TEST])
					mw_idx_r <= mw_idx_r + 3'h1;
				if (ctl[`BIT_RX_TEST] && !test_pattern_select_r)
				begin
					if (!o_prbs_locked)
					begin
						// Self-seed from incoming bits until a run matches
						prbs_chk_r <= {prbs_chk_r[6:0], rx_in};
						if (chk_diff == 8'h00)
						begin
							lock_cnt_r <= lock_cnt_r + 5'h08;
							if (lock_cnt_r >= `PRBS_LOCK_BITS)
								o_prbs_locked <= 1'b1;
						end
						else
							lock_cnt_r <= 5'h00;
					end
					else
					begin
						prbs_chk_r   <= chk_nxt;
						o_prbs_error <= (chk_diff != 8'h00);
					end
				end
			end
		end
	end

	byte_fifo #(
		.WIDTH (13),
		.DEPTH (8),
		.AW    (3)
	) u_tx_fifo (
		.i_ref_clk   (i_ref_clk),
		.i_rstn      (i_rstn),
		.i_in_valid  (i_slot_strobe),
		.i_in_data   ({i_slot_num, tx_byte}),
		.o_in_ready  (tx_ready),
		.o_out_valid (o_tx_valid),
		.o_out_data  ({o_tx_slot, o_tx_data}),
		.i_out_ready (i_tx_ready)
	);
endmodule // e1_slot_control

// ---- logic/slot_ctrl_defines.vh ----
// Constants for the per-slot control and one-second error latch block
// Function
// - One control word per slot; page A offsets 0x10-0x1F slots 0-15, page B 16-31.
// - Bit 7 set sends slot from transmit message buffer, else backplane input.
// - Bit 6 inverts alternate bits of backplane transmit and received line slot.
// - Bit 5 loops received line slot to transmit line; still on backplane output.
// - Bit 4 loops transmit slot into receive slot; still sent on line.
// - Bit 3 puts test signal in transmit slot: milliwatt if select=1, else PRBS.
// - Several slots may carry the transmit test pattern at once.
// - Bit 2 with select=1 puts milliwatt on backplane output slot.
// - Bit 2 with select=0 connects PRBS checker that locks and compares bitwise.
// - 10-bit E-bit count; upper bits at 0x10, lower byte at 0x11.
// - 8-bit errored frame alignment count at 0x12.
// - 16-bit bipolar violation count; upper byte 0x13, lower 0x14.
// - 10-bit CRC-4 count at 0x15/0x16; 0x17-0x1F unused.
// - Running counts copied to latches once per second by internal timer.
`ifndef SLOT_CTRL_DEFINES_VH
`define SLOT_CTRL_DEFINES_VH
`define PG_SLOT_LOW       5'h07
`define PG_SLOT_HIGH      5'h08
`define PG_STATUS         5'h09
`define PG_CONFIG         5'h02
`define OFS_CONFIG        5'h13
`define OFS_SLOT_FIRST    5'h10
`define OFS_EBIT_UP       5'h10
`define OFS_EBIT_LO       5'h11
`define OFS_FAS           5'h12
`define OFS_BPV_UP        5'h13
`define OFS_BPV_LO        5'h14
`define OFS_CRC_UP        5'h15
`define OFS_CRC_LO        5'h16
`define BIT_TX_MSG        7
`define BIT_ADI           6
`define BIT_REMOTE_LB     5
`define BIT_LOCAL_LB      4
`define BIT_TX_TEST       3
`define BIT_RX_TEST       2
`define BIT_PAT_SEL       0
`define SLOT_CTRL_RESET   8'h00
`define PRBS_SEED         15'h7fff
`define ADI_MASK          8'h55
`define MILLIWATT_LEN     8
`define CLK_HZ            50000000
`define ONE_SEC_NS        1000000000
`define ONE_SEC_CYCLES    (`CLK_HZ / 1000000 * (`ONE_SEC_NS / 1000))
`define PRBS_LOCK_BITS    5'd15
`endif

// ---- verification/e1_slot_control_sva.sv ----
// Port checker for the slot control and error latch block
`timescale 1ns/1ps
module e1_slot_control_sva(
	// Clock and reset
	input wire       i_ref_clk,
	input wire       i_rstn,
	// Register port
	input wire [4:0] i_page,
	input wire [4:0] i_addr,
	input wire       i_cs,
	input wire       i_wr,
	input wire [7:0] o_rdata,
	// Stream and status
	input wire       i_slot_strobe,
	input wire       o_tx_stall,
	input wire       o_backplane_valid,
	input wire       o_prbs_locked,
	input wire       o_prbs_error,
	input wire       o_one_sec_tick
);
	wire rd = i_cs && !i_wr;
	wire st = rd && i_page == 5'h09;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	a_rdata_idle_zero: assert property (!rd |-> o_rdata == 8'h00) else $error("read data not zero");
	a_slot_spare_bits: assert property (rd && (i_page == 5'h07 || i_page == 5'h08) && i_addr[4] |-> o_rdata[1:0] == 2'b00)
		else $error("slot word spare bits set");
	a_ebit_upper_width: assert property (st && i_addr == 5'h10 |-> o_rdata[7:2] == 6'h00)
		else $error("ebit upper byte too wide");
	a_status_unused_zero: assert property (st && i_addr > 5'h16 |-> o_rdata == 8'h00)
		else $error("unused status offset not zero");
	a_bp_out_follows: assert property (i_slot_strobe |=> o_backplane_valid) else $error("no backplane byte");
	a_tick_gap_held: assert property (o_one_sec_tick |=> !o_one_sec_tick [*8]) else $error("tick too soon");
	a_lock_held_on: assert property (o_prbs_locked |=> o_prbs_locked) else $error("lock dropped");
	a_err_needs_lock: assert property (o_prbs_error |-> $past(o_prbs_locked, 1) || o_prbs_locked)
		else $error("pattern error without lock");
	c_refused: cover property (i_slot_strobe && o_tx_stall);
	c_locked: cover property ($rose(o_prbs_locked));
	c_tick: cover property (o_one_sec_tick);
endmodule // e1_slot_control_sva

bind e1_slot_control e1_slot_control_sva u_sva(.i_ref_clk, .i_rstn, .i_page, .i_addr, .i_cs, .i_wr, .o_rdata,
	.i_slot_strobe, .o_tx_stall, .o_backplane_valid, .o_prbs_locked, .o_prbs_error, .o_one_sec_tick);

// ---- verification/tb.sv ----
// Self-checking bench for the slot control and error latch block
`timescale 1ns/1ps
module tb;
	localparam        SEC = 1000;
	localparam [63:0] MW  = 64'h34212134b4a1a1b4;
	localparam [39:0] TBL = 40'h0080402010;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg  [4:0]  page = 5'h00;
	reg  [4:0]  addr = 5'h00;
	reg  [4:0]  slot = 5'h00;
	reg         cs = 1'b0;
	reg         wr = 1'b0;
	reg         stb = 1'b0;
	reg         hold = 1'b0;
	reg         slow = 1'b1;
	reg  [7:0]  wdata = 8'h00;
	reg  [7:0]  bpin = 8'h00;
	reg  [7:0]  msg = 8'h00;
	reg  [7:0]  rx = 8'h00;
	reg  [3:0]  ev = 4'h0;
	wire [7:0]  rdata, txd, bpo;
	wire [4:0]  txs;
	wire        txv, rdy, stall, bpv, lock, perr, tick;
	reg  [7:0]  ctl [0:31];
	reg  [15:0] cnt [0:3];
	reg  [12:0] qt [$];
	reg  [7:0]  qb [$];
	reg  [7:0]  qr [$];
	reg  [14:0] ps;
	reg  [14:0] gs;
	reg  [31:0] r;
	reg  [7:0]  b;
	reg         sel;
	integer     fail_count = 0, samples_checked = 0, errs = 0, i, n, mi;
	e1_slot_control #(.ONE_SEC_CYCLES(SEC)) dut(.i_ref_clk(clk), .i_rstn(rstn), .i_page(page), .i_addr(addr),
		.i_cs(cs), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata), .i_slot_strobe(stb), .i_slot_num(slot),
		.i_backplane_data_input(bpin), .i_msg_buffer_data(msg), .i_rx_line_data(rx), .o_tx_valid(txv),
		.o_tx_data(txd), .o_tx_slot(txs), .i_tx_ready(rdy), .o_tx_stall(stall), .o_backplane_data_output(bpo),
		.o_backplane_valid(bpv), .o_prbs_locked(lock), .o_prbs_error(perr), .i_ebit_err(ev[0]),
		.i_fas_err(ev[1]), .i_bpv_err(ev[2]), .i_crc_err(ev[3]), .o_one_sec_tick(tick));
	tx_line_sink sink(.i_ref_clk(clk), .i_rstn(rstn), .i_hold(hold), .i_slow(slow), .o_tx_ready(rdy));
	always #10 clk = ~clk;
	task cmp(input string nm, input [15:0] e, input [15:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			fail_count = fail_count + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task cmp_bp;
	begin
		cmp("backplane", {8'h00, qb.size() > 0 ? qb.pop_front() : ~bpo}, {8'h00, bpo});
	end
	endtask
	task cmp_tx;
	begin
		cmp("tx line", {3'h0, qt.size() > 0 ? qt.pop_front() : ~{txs, txd}}, {3'h0, txs, txd});
	end
	endtask
	task cmp_rd;
	begin
		cmp("rdata", {8'h00, qr.size() > 0 ? qr.pop_front() : ~rdata}, {8'h00, rdata});
	end
	endtask
	task final_report;
	begin
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task tmo;
	begin
		cmp("wait", 16'h1, 16'h0);
		final_report;
	end
	endtask
	task bus(input w, input [9:0] pa, input [7:0] d);
	begin
		@(posedge clk);
		if (!w)
			qr.push_back(d);
		cs <= 1'b1;
		wr <= w;
		{page, addr} <= pa;
		wdata <= d;
		@(posedge clk);
		cs <= 1'b0;
	end
	endtask
	// Spare bits 1:0 read back as zero
	task wctl(input [4:0] s, input [7:0] v);
	begin
		ctl[s] = v & 8'hfc;
		bus(1'b1, {s[4] ? 5'h08 : 5'h07, 1'b1, s[3:0]}, v);
		bus(1'b0, {s[4] ? 5'h08 : 5'h07, 1'b1, s[3:0]}, ctl[s]);
	end
	endtask
	task drain;
	begin
		for (n = 0; qt.size() > 0 || qb.size() > 0; n = n + 1)
		begin
			if (n > 500)
				tmo;
			@(posedge clk);
		end
	end
	endtask
	task rst(input integer c);
	begin
		drain;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (c) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 32; i = i + 1)
			ctl[i] = 8'h00;
		sel = 1'b0;
		mi = 0;
		gs = 15'h7fff;
	end
	endtask
	task waittick;
	begin
		@(posedge clk);
		for (n = 0; !tick; n = n + 1)
		begin
			if (n > SEC + 50)
				tmo;
			@(posedge clk);
		end
	end
	endtask
	// Next eight bits of x^15+x^14+1, MSB first, with the advanced state above them
	function [22:0] nx8(input [14:0] s);
		reg [14:0] st;
		reg [7:0]  o;
		integer    j;
	begin
		st = s;
		o = 8'h00;
		for (j = 0; j < 8; j = j + 1)
		begin
			st = {st[13:0], st[14] ^ st[13]};
			o = {o[6:0], st[0]};
		end
		nx8 = {st, o};
	end
	endfunction
	// A refused strobe (frc while full) still shows on the backplane but loses its line byte
	task strobe(input [4:0] s, input [7:0] bp, input [7:0] m, input [7:0] rl, input frc);
		reg [7:0]  c, src, rxa, t;
		reg [22:0] g;
	begin
		c = ctl[s];
		g = nx8(gs);
		rxa = rl ^ (c[6] ? 8'h55 : 8'h00);
		src = c[7] ? m : bp ^ (c[6] ? 8'h55 : 8'h00);
		t = c[3] ? (sel ? MW[63 - 8 * mi -: 8] : g[7:0]) : c[5] ? rxa : src;
		@(posedge clk);
		for (n = 0; stall && !frc; n = n + 1)
		begin
			if (n > 200)
				tmo;
			@(posedge clk);
		end
		if (!stall)
			qt.push_back({s, t});
		if (!stall && c[3] && sel)
			mi = (mi + 1) % 8;
		if (!stall && c[3] && !sel)
			gs = g[22:8];
		qb.push_back((c[2] && sel) ? MW[63:56] : c[4] ? src : rxa);
		slot <= s;
		bpin <= bp;
		msg <= m;
		rx <= rl;
		stb <= 1'b1;
		@(posedge clk);
		stb <= 1'b0;
	end
	endtask
	always @(posedge clk)
	begin
		if (perr)
			errs = errs + 1;
		if (bpv)
			cmp_bp;
		if (txv && rdy)
			cmp_tx;
		if (cs && !wr)
			cmp_rd;
	end
	initial
	begin
		n = $urandom(32'h94f1);
		rst(12);
		for (i = 0; i < 32; i = i + 1)
		begin
			r = $urandom;
			bus(1'b0, {i[4] ? 5'h08 : 5'h07, 1'b1, i[3:0]}, 8'h00);
			wctl(i[4:0], TBL[8 * (i % 5) +: 8] | r[1:0]);
		end
		for (i = 0; i < 64; i = i + 1)
		begin
			r = $urandom;
			strobe(i[4:0], r[7:0], r[15:8], r[23:16], 1'b0);
		end
		drain;
		@(posedge clk);
		hold <= 1'b1;
		for (i = 0; i < 9; i = i + 1)
			strobe(5'h00, i[7:0], 8'h00, 8'h00, 1'b1);
		cmp("stall", 16'h1, {15'h0, stall});
		hold <= 1'b0;
		slow <= 1'b0;
		rst(2);
		bus(1'b1, {5'h02, 5'h13}, 8'h01);
		bus(1'b0, {5'h02, 5'h13}, 8'h01);
		sel = 1'b1;
		wctl(5'h03, 8'h04);
		strobe(5'h03, 8'h11, 8'h22, 8'h33, 1'b0);
		rst(2);
		bus(1'b1, {5'h02, 5'h13}, 8'h01);
		sel = 1'b1;
		wctl(5'h01, 8'h08);
		wctl(5'h02, 8'h08);
		for (i = 0; i < 10; i = i + 1)
			strobe(5'h01 + i[0], 8'h5a, 8'h00, 8'h00, 1'b0);
		rst(2);
		wctl(5'h05, 8'h04);
		wctl(5'h06, 8'h08);
		ps = 15'h7fff;
		for (i = 0; i < 7; i = i + 1)
		begin
			{ps, b} = nx8(ps);
			strobe(5'h05, 8'h00, 8'h00, i < 6 ? b : b ^ 8'h10, 1'b0);
			strobe(5'h06, b, 8'h00, 8'h00, 1'b0);
			if (i == 5)
				repeat (3) @(posedge clk);
			if (i == 5)
				cmp("locked", 16'h1, {15'h0, lock});
			if (i == 5)
				cmp("errors before fault", 16'h0, errs[15:0]);
		end
		repeat (3) @(posedge clk);
		cmp("pattern errors", 16'h1, errs[15:0]);
		waittick;
		for (i = 0; i < 4; i = i + 1)
			cnt[i] = $urandom_range(i == 1 ? 255 : 700, 1);
		for (i = 0; i < 701; i = i + 1)
		begin
			@(posedge clk);
			ev <= {i < cnt[3], i < cnt[2], i < cnt[1], i < cnt[0]};
		end
		waittick;
		cmp("tick period", SEC - 702, n[15:0]);
		bus(1'b1, {5'h09, 5'h12}, 8'hff);
		bus(1'b0, {5'h09, 5'h10}, {6'h00, cnt[0][9:8]});
		bus(1'b0, {5'h09, 5'h11}, cnt[0][7:0]);
		bus(1'b0, {5'h09, 5'h12}, cnt[1][7:0]);
		bus(1'b0, {5'h09, 5'h13}, cnt[2][15:8]);
		bus(1'b0, {5'h09, 5'h14}, cnt[2][7:0]);
		bus(1'b0, {5'h09, 5'h15}, {6'h00, cnt[3][9:8]});
		bus(1'b0, {5'h09, 5'h16}, cnt[3][7:0]);
		bus(1'b0, {5'h09, 5'h17}, 8'h00);
		drain;
		repeat (2) @(posedge clk);
		final_report;
	end
endmodule // tb

// ---- verification/tx_line_sink.sv ----
// Transmit line side model that drains the slot FIFO
`timescale 1ns/1ps
module tx_line_sink(
	// Clock and reset
	input  wire i_ref_clk,
	input  wire i_rstn,
	// Bench control: hold stalls fully, slow drains at random
	input  wire i_hold,
	input  wire i_slow,
	// Handshake
	output reg  o_tx_ready
);
	always @(posedge i_ref_clk)
		o_tx_ready <= i_rstn && !i_hold && (!i_slow || $urandom_range(1) == 1);
endmodule // tx_line_sink
